// ---- hdl/cfgl_pkg.sv ----
package cfgl_pkg;

    // erased configuration byte
    localparam logic [7:0] CFG_ERASED       = 8'hFF;

    // register byte offsets
    localparam logic [7:0] OFS_DF_BASE      = 8'h00;
    localparam logic [7:0] OFS_BROWNOUT     = 8'h04;
    localparam logic [7:0] OFS_WDT_CLK      = 8'h08;
    localparam logic [7:0] OFS_DF_ENABLE    = 8'h0C;
    localparam logic [7:0] OFS_RUN          = 8'h10;
    localparam logic [7:0] OFS_CTRL         = 8'h14;
    localparam logic [7:0] OFS_DF_START     = 8'h18;

    // configuration byte field positions
    localparam int BIT_BOD_EN_CFG   = 7;
    localparam int BIT_BOD_LVL_CFG  = 6;
    localparam int BIT_BOD_RST_CFG  = 4;
    localparam int BIT_WDT_EN_CFG   = 7;
    localparam int BIT_CLK_FILT_CFG = 4;
    localparam int BIT_RC_FREQ_CFG  = 3;
    localparam int BIT_SRC_HI_CFG   = 1;
    localparam int BIT_SRC_LO_CFG   = 0;
    localparam int BIT_DF_EN_CFG    = 0;

    // run-time control register field positions
    localparam int RUN_BOD_EN   = 0;
    localparam int RUN_BOD_LVL  = 1;
    localparam int RUN_BOD_RST  = 2;
    localparam int RUN_WDT_EN   = 3;
    localparam int RUN_CLK_FILT = 4;
    localparam int RUN_RC_FREQ  = 5;
    localparam int RUN_SRC_LO   = 6;
    localparam int RUN_SRC_HI   = 7;

    // run-time bits as loaded from erased bytes
    localparam logic [7:0] RUN_RESET        = 8'hF4;

    // control and status register fields
    localparam int CTRL_SW_RESET    = 0;
    localparam int CTRL_HOLD        = 0;
    localparam int CTRL_LAST_BOD    = 1;
    localparam int CTRL_MIN_PROG    = 2;

    // data flash base meaning no application memory
    localparam logic [7:0] DF_BASE_NONE     = 8'h00;
    localparam logic [7:0] DF_START_NONE    = 8'h00;

    // cycles the cpu is held before the copy
    localparam logic [2:0] LOAD_HOLD_CYCLES = 3'h4;

    // axi responses
    localparam logic [1:0] RESP_OKAY        = 2'h0;
    localparam logic [1:0] RESP_SLVERR      = 2'h2;

    typedef enum logic [1:0] {SEQ_HOLD, SEQ_LOAD, SEQ_RUN} cfgl_seq_state_type;

endpackage

// ---- hdl/cfgl_seq_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface cfgl_seq_if;
    logic req;
    logic load;
    logic hold;

    modport seq (input req, output load, output hold);
    modport user (output req, input load, input hold);
endinterface
`default_nettype wire

// ---- hdl/cfgl_sequencer.sv ----
`timescale 1ns/1ps
`default_nettype none
module cfgl_sequencer
    import cfgl_pkg::*;
(
    input  wire logic   aclk,
    input  wire logic   aresetn,
    cfgl_seq_if.seq     sq
);

    cfgl_seq_state_type state_r;
    cfgl_seq_state_type state_nxt;
    logic [2:0]         cnt_r;
    logic [2:0]         cnt_nxt;
    logic               hold_r;
    logic               hold_nxt;
    logic               load_r;
    logic               load_nxt;

    // hold, then one copy cycle, then release
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        case (state_r)
            SEQ_HOLD:
            begin
                if (sq.req)
                    cnt_nxt = 3'h0;
                else if (cnt_r == LOAD_HOLD_CYCLES - 3'h1)
                    state_nxt = SEQ_LOAD;
                else
                    cnt_nxt = cnt_r + 3'h1;
            end
            SEQ_LOAD:
            begin
                cnt_nxt   = 3'h0;
                state_nxt = sq.req ? SEQ_HOLD : SEQ_RUN;
            end
            default:
            begin
                cnt_nxt = 3'h0;
                if (sq.req)
                    state_nxt = SEQ_HOLD;
            end
        endcase
        hold_nxt = (state_nxt != SEQ_RUN);
        load_nxt = (state_nxt == SEQ_LOAD);
    end

    // sequencer state
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_r <= SEQ_HOLD;
            cnt_r   <= 3'h0;
            hold_r  <= 1'b1;
            load_r  <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            hold_r  <= hold_nxt;
            load_r  <= load_nxt;
        end
    end

    assign sq.hold = hold_r;
    assign sq.load = load_r;

    hold_length_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(hold_r) |-> hold_r [*5])
        else $error("cpu hold shorter than the load sequence");

    release_after_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $fell(hold_r) |-> $past(load_r))
        else $error("cpu released without a copy cycle");

endmodule
`default_nettype wire

// ---- hdl/cfgl_top.sv ----
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - data flash start high byte is the base byte, used only when data flash enabled
// - base byte zero means no application memory, minimum program region only
// - configuration bytes read all ones while erased, selecting defaults
// - brownout enable cfg bit 7: one disables detection, zero enables
// - every reset loads detect enable with inverse of brownout enable cfg
// - brownout level cfg one gives select zero, cfg zero gives select one
// - watchdog cfg bit 7: one leaves watchdog off, zero on after resets
// - reset loads watchdog run enable with inverse of watchdog cfg bit
// - resets, software reset included, copy cfg bits; software may change them later
// - clock filter cfg one enables the filter, zero disables it
// - clock source field: 11 internal rc, 00 crystal, 10 reserved
module cfgl_top
    import cfgl_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        ext_reset_n,
    input  wire logic        watchdog_reset,
    input  wire logic        brownout_below,
    output logic             cpu_reset_hold,
    output logic             brownout_detect_enable,
    output logic             brownout_level_select,
    output logic             brownout_reset_enable,
    output logic             watchdog_run_enable,
    output logic             clock_filter_enable,
    output logic             rc_frequency_select,
    output logic [1:0]       clock_source_sel,
    output logic             data_flash_present,
    output logic [7:0]       data_flash_start_high,
    output logic             min_program_region
);

    // mapped register offsets
    function automatic logic addr_mapped(input logic [7:0] a);
        addr_mapped = (a == OFS_DF_BASE) || (a == OFS_BROWNOUT) || (a == OFS_WDT_CLK)
                   || (a == OFS_DF_ENABLE) || (a == OFS_RUN) || (a == OFS_CTRL)
                   || (a == OFS_DF_START);
    endfunction

    // run-time bits derived from the two option bytes
    function automatic logic [7:0] run_from_cfg(input logic [7:0] bo, input logic [7:0] wc);
        logic [7:0] v;
        v               = 8'h00;
        v[RUN_BOD_EN]   = ~bo[BIT_BOD_EN_CFG];
        v[RUN_BOD_LVL]  = ~bo[BIT_BOD_LVL_CFG];
        v[RUN_BOD_RST]  = bo[BIT_BOD_RST_CFG];
        v[RUN_WDT_EN]   = ~wc[BIT_WDT_EN_CFG];
        v[RUN_CLK_FILT] = wc[BIT_CLK_FILT_CFG];
        v[RUN_RC_FREQ]  = wc[BIT_RC_FREQ_CFG];
        v[RUN_SRC_LO]   = wc[BIT_SRC_LO_CFG];
        v[RUN_SRC_HI]   = wc[BIT_SRC_HI_CFG];
        run_from_cfg    = v;
    endfunction

    cfgl_seq_if sq ();

    cfgl_sequencer u_seq (
        .aclk    (aclk),
        .aresetn (aresetn),
        .sq      (sq)
    );

    logic [7:0]  cfg_df_base_r, cfg_df_base_nxt;
    logic [7:0]  cfg_brownout_r, cfg_brownout_nxt;
    logic [7:0]  cfg_wdt_clk_r, cfg_wdt_clk_nxt;
    logic [7:0]  cfg_df_en_r, cfg_df_en_nxt;
    logic [7:0]  run_r, run_nxt;
    logic [7:0]  df_start_r, df_start_nxt;
    logic        df_present_r, df_present_nxt;
    logic        min_prog_r, min_prog_nxt;
    logic        sw_reset_r, sw_reset_nxt;
    logic        last_bod_r, last_bod_nxt;
    logic        bod_reset_r, bod_reset_nxt;
    logic        aw_have_r, aw_have_nxt;
    logic        w_have_r, w_have_nxt;
    logic [7:0]  awaddr_r, awaddr_nxt;
    logic [7:0]  wdata_r, wdata_nxt;
    logic        wstrb0_r, wstrb0_nxt;
    logic        awready_r, awready_nxt;
    logic        wready_r, wready_nxt;
    logic        bvalid_r, bvalid_nxt;
    logic [1:0]  bresp_r, bresp_nxt;
    logic        arready_r, arready_nxt;
    logic        rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0]  rresp_r, rresp_nxt;
    logic        ext_s1_r, ext_s2_r;
    logic        bod_s1_r, bod_s2_r, bod_prev_r;
    logic        wr_go;
    logic        bod_cross;

    // pin synchronisers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ext_s1_r   <= 1'b1;
            ext_s2_r   <= 1'b1;
            bod_s1_r   <= 1'b0;
            bod_s2_r   <= 1'b0;
            bod_prev_r <= 1'b0;
        end
        else
        begin
            ext_s1_r   <= ext_reset_n;
            ext_s2_r   <= ext_s1_r;
            bod_s1_r   <= brownout_below;
            bod_s2_r   <= bod_s1_r;
            bod_prev_r <= bod_s2_r;
        end
    end

    // reset sources into the sequencer
    assign bod_cross = bod_s2_r ^ bod_prev_r;
    assign sq.req    = ~ext_s2_r | watchdog_reset | sw_reset_r | bod_reset_r;
    assign wr_go     = aw_have_r & w_have_r & ~bvalid_r;

    // bus slave, option bytes and loaded run-time bits
    always_comb
    begin
        cfg_df_base_nxt  = cfg_df_base_r;
        cfg_brownout_nxt = cfg_brownout_r;
        cfg_wdt_clk_nxt  = cfg_wdt_clk_r;
        cfg_df_en_nxt    = cfg_df_en_r;
        run_nxt          = run_r;
        df_start_nxt     = df_start_r;
        df_present_nxt   = df_present_r;
        min_prog_nxt     = min_prog_r;
        sw_reset_nxt     = 1'b0;
        last_bod_nxt     = last_bod_r;
        aw_have_nxt      = aw_have_r;
        w_have_nxt       = w_have_r;
        awaddr_nxt       = awaddr_r;
        wdata_nxt        = wdata_r;
        wstrb0_nxt       = wstrb0_r;
        bvalid_nxt       = bvalid_r;
        bresp_nxt        = bresp_r;
        rvalid_nxt       = rvalid_r;
        rdata_nxt        = rdata_r;
        rresp_nxt        = rresp_r;
        bod_reset_nxt    = bod_cross & run_r[RUN_BOD_EN] & run_r[RUN_BOD_RST];
        if (s_axi_awvalid && awready_r)
        begin
            aw_have_nxt = 1'b1;
            awaddr_nxt  = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_r)
        begin
            w_have_nxt = 1'b1;
            wdata_nxt  = s_axi_wdata[7:0];
            wstrb0_nxt = s_axi_wstrb[0];
        end
        if (bvalid_r && s_axi_bready)
            bvalid_nxt = 1'b0;
        if (wr_go)
        begin
            aw_have_nxt = 1'b0;
            w_have_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = addr_mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
            if (wstrb0_r)
            begin
                if (awaddr_r == OFS_DF_BASE)
                    cfg_df_base_nxt = wdata_r;
                else if (awaddr_r == OFS_BROWNOUT)
                    cfg_brownout_nxt = wdata_r;
                else if (awaddr_r == OFS_WDT_CLK)
                    cfg_wdt_clk_nxt = wdata_r;
                else if (awaddr_r == OFS_DF_ENABLE)
                    cfg_df_en_nxt = wdata_r;
                else if (awaddr_r == OFS_RUN)
                    run_nxt = wdata_r;
                else if (awaddr_r == OFS_CTRL)
                begin
                    sw_reset_nxt = wdata_r[CTRL_SW_RESET];
                    if (wdata_r[CTRL_LAST_BOD])
                        last_bod_nxt = 1'b0;
                end
            end
        end
        if (bod_reset_r)
            last_bod_nxt = 1'b1;  // set wins over clear
        // copy at every reset, software reset included
        if (sq.load)
        begin
            run_nxt        = run_from_cfg(cfg_brownout_r, cfg_wdt_clk_r);
            df_present_nxt = ~cfg_df_en_r[BIT_DF_EN_CFG];
            df_start_nxt   = cfg_df_en_r[BIT_DF_EN_CFG] ? DF_START_NONE
                                                        : cfg_df_base_r;
            min_prog_nxt   = ~cfg_df_en_r[BIT_DF_EN_CFG]
                           & (cfg_df_base_r == DF_BASE_NONE);
        end
        if (rvalid_r && s_axi_rready)
            rvalid_nxt = 1'b0;
        if (s_axi_arvalid && arready_r)
        begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            rdata_nxt  = 32'h0000_0000;
            if (s_axi_araddr == OFS_DF_BASE)
                rdata_nxt[7:0] = cfg_df_base_r;
            else if (s_axi_araddr == OFS_BROWNOUT)
                rdata_nxt[7:0] = cfg_brownout_r;
            else if (s_axi_araddr == OFS_WDT_CLK)
                rdata_nxt[7:0] = cfg_wdt_clk_r;
            else if (s_axi_araddr == OFS_DF_ENABLE)
                rdata_nxt[7:0] = cfg_df_en_r;
            else if (s_axi_araddr == OFS_RUN)
                rdata_nxt[7:0] = run_r;
            else if (s_axi_araddr == OFS_CTRL)
            begin
                rdata_nxt[CTRL_HOLD]     = sq.hold;
                rdata_nxt[CTRL_LAST_BOD] = last_bod_r;
                rdata_nxt[CTRL_MIN_PROG] = min_prog_r;
            end
            else if (s_axi_araddr == OFS_DF_START)
                rdata_nxt[7:0] = df_start_r;
        end
        awready_nxt = ~aw_have_nxt & ~bvalid_nxt;
        wready_nxt  = ~w_have_nxt & ~bvalid_nxt;
        arready_nxt = ~rvalid_nxt;
    end

    // register stage; option bytes come back erased only on power-up
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cfg_df_base_r  <= CFG_ERASED;
            cfg_brownout_r <= CFG_ERASED;
            cfg_wdt_clk_r  <= CFG_ERASED;
            cfg_df_en_r    <= CFG_ERASED;
            run_r          <= RUN_RESET;
            df_start_r     <= DF_START_NONE;
            df_present_r   <= 1'b0;
            min_prog_r     <= 1'b0;
            sw_reset_r     <= 1'b0;
            last_bod_r     <= 1'b0;
            bod_reset_r    <= 1'b0;
            aw_have_r      <= 1'b0;
            w_have_r       <= 1'b0;
            awaddr_r       <= 8'h00;
            wdata_r        <= 8'h00;
            wstrb0_r       <= 1'b0;
            awready_r      <= 1'b0;
            wready_r       <= 1'b0;
            bvalid_r       <= 1'b0;
            bresp_r        <= RESP_OKAY;
            arready_r      <= 1'b0;
            rvalid_r       <= 1'b0;
            rdata_r        <= 32'h0000_0000;
            rresp_r        <= RESP_OKAY;
        end
        else
        begin
            cfg_df_base_r  <= cfg_df_base_nxt;
            cfg_brownout_r <= cfg_brownout_nxt;
            cfg_wdt_clk_r  <= cfg_wdt_clk_nxt;
            cfg_df_en_r    <= cfg_df_en_nxt;
            run_r          <= run_nxt;
            df_start_r     <= df_start_nxt;
            df_present_r   <= df_present_nxt;
            min_prog_r     <= min_prog_nxt;
            sw_reset_r     <= sw_reset_nxt;
            last_bod_r     <= last_bod_nxt;
            bod_reset_r    <= bod_reset_nxt;
            aw_have_r      <= aw_have_nxt;
            w_have_r       <= w_have_nxt;
            awaddr_r       <= awaddr_nxt;
            wdata_r        <= wdata_nxt;
            wstrb0_r       <= wstrb0_nxt;
            awready_r      <= awready_nxt;
            wready_r       <= wready_nxt;
            bvalid_r       <= bvalid_nxt;
            bresp_r        <= bresp_nxt;
            arready_r      <= arready_nxt;
            rvalid_r       <= rvalid_nxt;
            rdata_r        <= rdata_nxt;
            rresp_r        <= rresp_nxt;
        end
    end

    // outputs, all from flops
    assign s_axi_awready          = awready_r;
    assign s_axi_wready           = wready_r;
    assign s_axi_bvalid           = bvalid_r;
    assign s_axi_bresp            = bresp_r;
    assign s_axi_arready          = arready_r;
    assign s_axi_rvalid           = rvalid_r;
    assign s_axi_rdata            = rdata_r;
    assign s_axi_rresp            = rresp_r;
    assign cpu_reset_hold         = sq.hold;
    assign brownout_detect_enable = run_r[RUN_BOD_EN];
    assign brownout_level_select  = run_r[RUN_BOD_LVL];
    assign brownout_reset_enable  = run_r[RUN_BOD_RST];
    assign watchdog_run_enable    = run_r[RUN_WDT_EN];
    assign clock_filter_enable    = run_r[RUN_CLK_FILT];
    assign rc_frequency_select    = run_r[RUN_RC_FREQ];
    assign clock_source_sel       = {run_r[RUN_SRC_HI], run_r[RUN_SRC_LO]};
    assign data_flash_present     = df_present_r;
    assign data_flash_start_high  = df_start_r;
    assign min_program_region     = min_prog_r;

    erased_bytes_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !$past(aresetn) |-> (cfg_df_base_r == CFG_ERASED && cfg_brownout_r == CFG_ERASED
                             && cfg_wdt_clk_r == CFG_ERASED))
        else $error("option bytes not erased after power-up");

    bod_enable_copy_a: assert property (@(posedge aclk) disable iff (!aresetn)
        sq.load |=> brownout_detect_enable == !$past(cfg_brownout_r[BIT_BOD_EN_CFG]))
        else $error("detect enable not inverse of option bit");

    bod_level_copy_a: assert property (@(posedge aclk) disable iff (!aresetn)
        sq.load |=> brownout_level_select != $past(cfg_brownout_r[BIT_BOD_LVL_CFG]))
        else $error("level select not inverse of option bit");

    wdt_enable_copy_a: assert property (@(posedge aclk) disable iff (!aresetn)
        sq.load |=> watchdog_run_enable == !$past(cfg_wdt_clk_r[BIT_WDT_EN_CFG]))
        else $error("watchdog enable not inverse of option bit");

    clock_copy_a: assert property (@(posedge aclk) disable iff (!aresetn)
        sq.load |=> (clock_filter_enable == $past(cfg_wdt_clk_r[BIT_CLK_FILT_CFG])
            && clock_source_sel == $past(cfg_wdt_clk_r[BIT_SRC_HI_CFG:BIT_SRC_LO_CFG])))
        else $error("clock options not copied");

    bod_reset_req_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (bod_cross && brownout_detect_enable && brownout_reset_enable) |=> sq.req ##1 sq.hold)
        else $error("brownout crossing gave no reset");

    flash_base_a: assert property (@(posedge aclk) disable iff (!aresetn)
        sq.load |=> (data_flash_present == !$past(cfg_df_en_r[BIT_DF_EN_CFG]))
            && (data_flash_present || data_flash_start_high == DF_START_NONE))
        else $error("data flash base honoured while disabled");

    min_region_a: assert property (@(posedge aclk) disable iff (!aresetn)
        sq.load |=> min_program_region == (!$past(cfg_df_en_r[BIT_DF_EN_CFG])
                                           && $past(cfg_df_base_r) == DF_BASE_NONE))
        else $error("minimum program region wrong");

    sw_reset_reload_a: assert property (@(posedge aclk) disable iff (!aresetn)
        sw_reset_r |-> ##[1:7] sq.load)
        else $error("software reset did not reload");

endmodule
`default_nettype wire

// ---- verification/config_byte_reset_reload_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module config_byte_reset_reload_test;
    import cfgl_pkg::*;
    logic        aclk, aresetn, ext_reset_n, watchdog_reset, brownout_below;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, data_flash_start_high;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, clock_source_sel;
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        cpu_reset_hold, brownout_detect_enable, brownout_level_select;
    logic        brownout_reset_enable, watchdog_run_enable, clock_filter_enable;
    logic        rc_frequency_select, data_flash_present, min_program_region;
    logic [7:0]  m_base, m_bod, m_wdt, m_data_flash_enable_cfg, e_run, e_start;
    logic        e_pres, e_min;
    int          n_mismatch, num_checks, cycles;
    integer      seed;

    cfgl_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_reset_n, .watchdog_reset,
        .brownout_below, .cpu_reset_hold, .brownout_detect_enable, .brownout_level_select,
        .brownout_reset_enable, .watchdog_run_enable, .clock_filter_enable,
        .rc_frequency_select, .clock_source_sel, .data_flash_present, .data_flash_start_high,
        .min_program_region);

    // compare and count
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // axi write, address and data offered together
    task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        bit aw_done, w_done;
        aw_done = 0;
        w_done = 0;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (!(aw_done && w_done))
        begin
            @(posedge aclk);
            aw_done |= s_axi_awready;
            w_done |= s_axi_wready;
            s_axi_awvalid <= !aw_done;
            s_axi_wvalid  <= !w_done;
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk("bresp", 32'(er), 32'(s_axi_bresp));
    endtask

    // axi read with expected data and response
    task automatic axi_rd(input string nm, input logic [7:0] a, input logic [31:0] e,
                          input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk(nm, e, s_axi_rdata);
        chk("rresp", 32'(er), 32'(s_axi_rresp));
    endtask

    // model of the copy done at every reload
    task automatic load();
        e_run   = {m_wdt[1:0], m_wdt[3], m_wdt[4], ~m_wdt[7], m_bod[4], ~m_bod[6], ~m_bod[7]};
        e_pres  = !m_data_flash_enable_cfg[0];
        e_start = e_pres ? m_base : 8'h00;
        e_min   = e_pres && (m_base == 8'h00);
    endtask

    // loaded outputs against the model
    task automatic chk_outs();
        chk("run bits", 32'(e_run), 32'({clock_source_sel, rc_frequency_select,
            clock_filter_enable, watchdog_run_enable, brownout_reset_enable,
            brownout_level_select, brownout_detect_enable}));
        chk("df present", 32'(e_pres), 32'(data_flash_present));
        chk("df start", 32'(e_start), 32'(data_flash_start_high));
        chk("min region", 32'(e_min), 32'(min_program_region));
        axi_rd("run reg", OFS_RUN, 32'(e_run), RESP_OKAY);
        axi_rd("start reg", OFS_DF_START, 32'(e_start), RESP_OKAY);
    endtask

    // wait for hold to rise and fall, bounded
    task automatic wait_reload(input logic e);
        repeat (30) if (!cpu_reset_hold) @(posedge aclk);
        chk("hold rise", 32'(e), 32'(cpu_reset_hold));
        repeat (30) if (cpu_reset_hold) @(posedge aclk);
        chk("hold fall", 32'h0, 32'(cpu_reset_hold));
    endtask

    // reset sources: 0 software, 1 pin, 2 watchdog, 3 supply crossing
    task automatic fire(input int src);
        @(posedge aclk);
        ext_reset_n    <= (src != 1);
        watchdog_reset <= (src == 2);
        if (src == 3)
            brownout_below <= !brownout_below;
        if (src == 0)
            axi_wr(OFS_CTRL, 8'h01, RESP_OKAY);
        repeat (2) @(posedge aclk);
        ext_reset_n    <= 1'b1;
        watchdog_reset <= 1'b0;
    endtask

    task automatic wr_bytes();
        axi_wr(OFS_DF_BASE, m_base, RESP_OKAY);
        axi_wr(OFS_BROWNOUT, m_bod, RESP_OKAY);
        axi_wr(OFS_WDT_CLK, m_wdt, RESP_OKAY);
        axi_wr(OFS_DF_ENABLE, m_data_flash_enable_cfg, RESP_OKAY);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // clock
    initial
    begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    // hang guard
    always @(posedge aclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_mismatch++;
            complete_run();
        end
    end

    // main sequence
    initial
    begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready, watchdog_reset, brownout_below} = '0;
        {aresetn, cycles, n_mismatch, num_checks} = '0;
        s_axi_wstrb = 4'hF;
        ext_reset_n = 1'b1;
        seed = 32'hA39BBDC7;
        {m_base, m_bod, m_wdt, m_data_flash_enable_cfg} = {4{CFG_ERASED}};
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        load();
        wait_reload(1'b1);
        chk_outs();
        for (int i = 0; i < 4; i++)
            axi_rd("option byte", 8'(4 * i), 32'h000000FF, RESP_OKAY);
        axi_rd("ctrl", OFS_CTRL, 32'h0, RESP_OKAY);
        axi_rd("unmapped", 8'h1C, 32'h0, RESP_SLVERR);
        axi_wr(8'h1C, 8'h55, RESP_SLVERR);
        s_axi_wstrb <= 4'hE;
        axi_wr(OFS_DF_BASE, 8'h3C, RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        axi_rd("no store", OFS_DF_BASE, 32'(m_base), RESP_OKAY);
        for (int i = 0; i < 4; i++)
        begin
            m_base = (i == 0) ? 8'h00 : 8'($random(seed));
            m_bod  = 8'($random(seed));
            m_wdt  = {6'($random(seed)), 2'(i)};
            m_data_flash_enable_cfg = {7'h7F, i == 3};
            wr_bytes();
            chk_outs();
            fire(i % 3);
            load();
            wait_reload(1'b1);
            chk_outs();
            axi_rd("ctrl", OFS_CTRL, {29'h0, e_min, 2'b00}, RESP_OKAY);
        end
        e_run = 8'($random(seed));
        axi_wr(OFS_RUN, e_run, RESP_OKAY);
        chk_outs();
        fire(2);
        load();
        wait_reload(1'b1);
        chk_outs();
        m_bod = 8'h10;
        wr_bytes();
        fire(0);
        load();
        wait_reload(1'b1);
        chk_outs();
        fire(3);
        wait_reload(1'b1);
        axi_rd("ctrl", OFS_CTRL, {29'h0, e_min, 2'b10}, RESP_OKAY);
        axi_wr(OFS_CTRL, 8'h02, RESP_OKAY);
        axi_rd("ctrl clr", OFS_CTRL, {29'h0, e_min, 2'b00}, RESP_OKAY);
        fire(3);
        wait_reload(1'b1);
        m_bod = 8'hFF;
        wr_bytes();
        fire(0);
        load();
        wait_reload(1'b1);
        fire(3);
        wait_reload(1'b0);
        chk_outs();
        aresetn <= 1'b0;
        {m_base, m_bod, m_wdt, m_data_flash_enable_cfg} = {4{CFG_ERASED}};
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        load();
        wait_reload(1'b1);
        chk_outs();
        axi_rd("ctrl", OFS_CTRL, 32'h0, RESP_OKAY);
        complete_run();
    end
endmodule
`default_nettype wire
